// ---- byte_fifo.sv ----
// Purpose: data byte buffer in front of the write sequencer
// Assumes: depth is a power of two
// Notes:   in_ready is registered
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready  <= (count_next < (AW+1)'(DEPTH));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  fifo_no_over_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo count over depth");

  fifo_full_stall_a : assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (count_reg == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("fifo ready while full");

endmodule : byte_fifo
`default_nettype wire

// ---- eprom_dev_model.sv ----
// Purpose: device model on the far side of the wire
// Assumes: sys_clk only paces the model
// Notes:   line is pulled up whenever nobody pulls it low
`timescale 1ns/100ps
`default_nettype none
module eprom_dev_model (
  // clock
  input  wire logic sys_clk,
  // master pins
  input  wire logic dq_oe,
  input  wire logic prog_en,
  // wire level
  output logic      line
);
  // ****************
  // state
  // ****************
  logic        pull = 0, mute = 0, bad_crc = 0;
  logic [7:0]  stuck = 8'h00, cmd, b;
  logic [15:0] adr, crc;
  logic [7:0]  smem [2048];
  logic [7:0]  dmem [2048];
  int          low_n = 0, progs = 0;

  assign line = !(dq_oe || pull);

  // ****************
  // slots
  // ****************
  task automatic sync();
    while (!line) @(posedge sys_clk);
    while (line) @(posedge sys_clk);
  endtask : sync

  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      sync();
      repeat (30) @(posedge sys_clk);
      v[i] = line;
      crc = (crc >> 1) ^ (crc[0] ^ line ? 16'ha001 : 16'h0);
    end
  endtask : rx

  task automatic tx(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      sync();
      pull <= !v[i];
      repeat (30) @(posedge sys_clk);
      pull <= 0;
    end
  endtask : tx

  // ****************
  // long low aborts
  // ****************
  always @(posedge sys_clk) begin
    low_n <= line ? 0 : low_n + 1;
    if (low_n == 120) begin
      pull <= 0;
      disable txn;
    end
  end

  // ****************
  // transaction
  // ****************
  initial begin
    foreach (smem[i]) begin
      smem[i] = 8'hff;
      dmem[i] = 8'hff;
    end
    forever begin : txn
      wait (low_n > 120);
      wait (line);
      if (!mute) begin
        repeat (15) @(posedge sys_clk);
        pull <= 1;
        repeat (60) @(posedge sys_clk);
        pull <= 0;
      end
      rx(b);
      crc = 16'h0;
      rx(cmd);
      if (!(cmd inside {8'h0f, 8'hf3, 8'h55, 8'hf5})) wait (0);
      rx(adr[7:0]);
      rx(adr[15:8]);
      forever begin
        rx(b);
        if (cmd == 8'h0f || cmd == 8'h55) begin
          tx(~crc ^ {15'h0, bad_crc}, 16);
          bad_crc = 0;
        end
        // programs even after a bad crc
        @(negedge prog_en);
        progs++;
        if (cmd[3:0] == 4'h5) begin
          smem[adr[10:0]] &= b | stuck;
          tx({8'h00, smem[adr[10:0]]}, 8);
        end else begin
          dmem[adr[10:0]] &= b | stuck;
          tx({8'h00, dmem[adr[10:0]]}, 8);
        end
        adr++;
        crc = adr;
      end
    end
  end
endmodule : eprom_dev_model
`default_nettype wire

// ---- eprom_params.svh ----
// Purpose: constants for the single-wire EPROM write master
// Assumes: 100 MHz sys_clk
// Notes:   times in microseconds, counts derived in the modules
`ifndef EPROM_PARAMS_SVH
`define EPROM_PARAMS_SVH

// ****************************************
// clock and bus timing
// ****************************************
`define CLK_MHZ         100
`define RST_LOW_US      480
`define RST_HIGH_US     480
`define PRES_SAMPLE_US  70
`define PROG_US         480
`define SLOT_US         70
`define LOW0_US         60
`define LOW1_US         6
`define RD_SAMPLE_US    13
`define REC_US          5

// ****************************************
// command codes
// ****************************************
`define CMD_SKIP_ROM    8'hCC
`define CMD_WR_MEM      8'h0F
`define CMD_SPD_MEM     8'hF3
`define CMD_WR_STAT     8'h55
`define CMD_SPD_STAT    8'hF5

// ****************************************
// crc, retry and fifo size
// ****************************************
`define CRC_POLY_REV    16'hA001
`define CRC_RD_INVERT   1'h1
`define MAX_RETRY       2'h3
`define FIFO_DEPTH      16
`define FIFO_WIDTH      8

`endif

// ---- eprom_pkg.sv ----
// Purpose: types for the single-wire EPROM write master
// Assumes: nothing
// Notes:   constants live in eprom_params.svh
package eprom_pkg;

  typedef struct packed {
    logic        speed;
    logic        status;
    logic [15:0] addr;
    logic [7:0]  count;
  } job_t;

  typedef struct packed {
    logic presence;
    logic crc;
    logic verify;
  } err_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RST_LO = 3'h1,
    ST_RST_HI = 3'h2,
    ST_SLOT   = 3'h3,
    ST_NEXT   = 3'h4,
    ST_FETCH  = 3'h5,
    ST_PROG   = 3'h6,
    ST_FIN    = 3'h7
  } state_t;

  typedef enum logic [2:0] {
    SP_ROM  = 3'h0,
    SP_MEM  = 3'h1,
    SP_ALO  = 3'h2,
    SP_AHI  = 3'h3,
    SP_DATA = 3'h4,
    SP_CRC  = 3'h5,
    SP_VER  = 3'h6
  } step_t;

endpackage : eprom_pkg

// ---- eprom_status_write_sequencer.sv ----
// Purpose: bus master that programs status or data bytes over one wire
// Assumes: dq_in synchronous to sys_clk; external switch on prog_en
// Notes:   retries a byte from reset when crc or readback fails
`timescale 1ns/100ps
`default_nettype none
`include "eprom_params.svh"
module eprom_status_write_sequencer #(
  parameter logic [15:0] RST_LOW_CYC  = 16'(`RST_LOW_US * `CLK_MHZ),
  parameter logic [15:0] RST_HIGH_CYC = 16'(`RST_HIGH_US * `CLK_MHZ),
  parameter logic [15:0] PRES_CYC     = 16'(`PRES_SAMPLE_US * `CLK_MHZ),
  parameter logic [15:0] PROG_CYC     = 16'(`PROG_US * `CLK_MHZ),
  parameter logic [15:0] SLOT_CYC     = 16'(`SLOT_US * `CLK_MHZ),
  parameter logic [15:0] LOW0_CYC     = 16'(`LOW0_US * `CLK_MHZ)
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // job request and result
  input  wire logic         start,
  input  wire eprom_pkg::job_t job,
  output logic              busy,
  output logic              done,
  output eprom_pkg::err_t   err,
  // data bytes
  input  wire logic [7:0]   wr_data,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  // bus pins
  input  wire logic         dq_in,
  output logic              dq_out,
  output logic              dq_oe,
  output logic              prog_en
);
  // sub-slot points scale with the slot, so a short slot stays legal
  localparam logic [15:0] LOW1_CYC =
    16'(32'(SLOT_CYC) * `LOW1_US / `SLOT_US);
  localparam logic [15:0] SMP_CYC  =
    16'(32'(SLOT_CYC) * `RD_SAMPLE_US / `SLOT_US);
  localparam logic [15:0] REC_CYC  =
    16'(32'(SLOT_CYC) * `REC_US / `SLOT_US);
  localparam logic [15:0] SLOT_END = 16'(SLOT_CYC + REC_CYC - 16'h1);
  localparam logic [15:0] PROG_END = 16'(PROG_CYC + REC_CYC - 16'h1);

  eprom_pkg::state_t state_reg;
  eprom_pkg::step_t  step_reg;
  eprom_pkg::job_t   job_reg;
  logic [15:0] tmr_reg;
  logic [4:0]  bits_reg;
  logic [7:0]  tx_reg;
  logic [15:0] rx_reg;
  logic [15:0] crc_reg;
  logic [15:0] addr_reg;
  logic [7:0]  count_reg;
  logic [7:0]  data_reg;
  logic        have_reg;
  logic [1:0]  retry_reg;
  logic        pres_reg;
  logic        crc_ok_reg;
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  function automatic logic [15:0] crc_bit(input logic [15:0] c,
                                          input logic b);
    logic [15:0] s;
    s = {1'b0, c[15:1]};
    if (c[0] ^ b) begin
      s = s ^ `CRC_POLY_REV;
    end
    return s;
  endfunction : crc_bit

  function automatic logic [7:0] mem_cmd(input eprom_pkg::job_t j);
    logic [7:0] c;
    // speed codes only when the caller vouches for contact
    c = j.status ? (j.speed ? `CMD_SPD_STAT : `CMD_WR_STAT)
                 : (j.speed ? `CMD_SPD_MEM : `CMD_WR_MEM);
    return c;
  endfunction : mem_cmd

  // ****************************************
  // data buffer
  // ****************************************
  assign fifo_pop = (state_reg == eprom_pkg::ST_FETCH) && !have_reg;

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg  <= eprom_pkg::ST_IDLE;
      step_reg   <= eprom_pkg::SP_ROM;
      job_reg    <= '0;
      err        <= '0;
      tmr_reg    <= 16'h0000;
      bits_reg   <= 5'h00;
      tx_reg     <= 8'hFF;
      rx_reg     <= 16'h0000;
      crc_reg    <= 16'h0000;
      addr_reg   <= 16'h0000;
      count_reg  <= 8'h00;
      data_reg   <= 8'hFF;
      have_reg   <= 1'b0;
      retry_reg  <= 2'h0;
      pres_reg   <= 1'b0;
      crc_ok_reg <= 1'b0;
    end else begin
      tmr_reg  <= tmr_reg + 16'h0001;
      case (state_reg)
        eprom_pkg::ST_IDLE: begin
          tmr_reg <= 16'h0000;
          if (start) begin
            job_reg   <= job;
            addr_reg  <= job.addr;
            count_reg <= job.count;
            have_reg  <= 1'b0;
            retry_reg <= 2'h0;
            step_reg  <= eprom_pkg::SP_ROM;
            err       <= '0;
            state_reg <= (job.count == 8'h00) ? eprom_pkg::ST_FIN
                                              : eprom_pkg::ST_RST_LO;
          end
        end
        eprom_pkg::ST_RST_LO: begin
          crc_ok_reg <= 1'b0;
          if (tmr_reg == 16'(RST_LOW_CYC - 16'h1)) begin
            tmr_reg   <= 16'h0000;
            pres_reg  <= 1'b0;
            state_reg <= eprom_pkg::ST_RST_HI;
          end
        end
        eprom_pkg::ST_RST_HI: begin
          if (tmr_reg == PRES_CYC) begin
            pres_reg <= !dq_in;
          end
          if (tmr_reg == 16'(RST_HIGH_CYC - 16'h1)) begin
            tmr_reg <= 16'h0000;
            if (!pres_reg) begin
              err.presence <= 1'b1;
              state_reg <= eprom_pkg::ST_FIN;
            end else begin
              step_reg  <= eprom_pkg::SP_ROM;
              tx_reg    <= `CMD_SKIP_ROM;
              bits_reg  <= 5'h08;
              state_reg <= eprom_pkg::ST_SLOT;
            end
          end
        end
        eprom_pkg::ST_SLOT: begin
          if (tmr_reg == SMP_CYC) begin
            rx_reg <= {dq_in, rx_reg[15:1]};
          end
          if (tmr_reg == SLOT_END) begin
            tmr_reg  <= 16'h0000;
            tx_reg   <= {1'b1, tx_reg[7:1]};
            bits_reg <= bits_reg - 5'h01;
            if (step_reg inside {eprom_pkg::SP_MEM, eprom_pkg::SP_ALO,
                                 eprom_pkg::SP_AHI, eprom_pkg::SP_DATA}) begin
              crc_reg <= crc_bit(crc_reg, tx_reg[0]);
            end
            state_reg <= eprom_pkg::ST_NEXT;
          end
        end
        eprom_pkg::ST_NEXT: begin
          tmr_reg   <= 16'h0000;
          state_reg <= eprom_pkg::ST_SLOT;
          if (bits_reg == 5'h00) begin
            bits_reg <= 5'h08;
            case (step_reg)
              eprom_pkg::SP_ROM: begin
                step_reg <= eprom_pkg::SP_MEM;
                tx_reg   <= mem_cmd(job_reg);
                crc_reg  <= 16'h0000;
              end
              eprom_pkg::SP_MEM: begin
                step_reg <= eprom_pkg::SP_ALO;
                tx_reg   <= addr_reg[7:0];
              end
              eprom_pkg::SP_ALO: begin
                step_reg <= eprom_pkg::SP_AHI;
                tx_reg   <= addr_reg[15:8];
              end
              eprom_pkg::SP_AHI: begin
                step_reg  <= eprom_pkg::SP_DATA;
                state_reg <= eprom_pkg::ST_FETCH;
              end
              eprom_pkg::SP_DATA: begin
                if (job_reg.speed) begin
                  state_reg <= eprom_pkg::ST_PROG;
                end else begin
                  step_reg <= eprom_pkg::SP_CRC;
                  tx_reg   <= 8'hFF;
                  bits_reg <= 5'h10;
                end
              end
              eprom_pkg::SP_CRC: begin
                // device cannot judge the crc, so the master must
                if (rx_reg == (`CRC_RD_INVERT ? ~crc_reg : crc_reg)) begin
                  crc_ok_reg <= 1'b1;
                  state_reg  <= eprom_pkg::ST_PROG;
                end else begin
                  err.crc   <= (retry_reg == `MAX_RETRY);
                  // a fresh reset abandons the byte
                  retry_reg <= retry_reg + 2'h1;
                  state_reg <= (retry_reg == `MAX_RETRY) ? eprom_pkg::ST_FIN
                                                 : eprom_pkg::ST_RST_LO;
                end
              end
              eprom_pkg::SP_VER: begin
                if (|(rx_reg[15:8] & ~data_reg)) begin
                  // reset aborts, same address reprogrammed
                  err.verify <= (retry_reg == `MAX_RETRY);
                  retry_reg <= retry_reg + 2'h1;
                  state_reg <= (retry_reg == `MAX_RETRY) ? eprom_pkg::ST_FIN
                                                 : eprom_pkg::ST_RST_LO;
                end else begin
                  // device moved on and preloads its crc
                  addr_reg  <= addr_reg + 16'h0001;
                  crc_reg   <= addr_reg + 16'h0001;
                  count_reg <= count_reg - 8'h01;
                  have_reg  <= 1'b0;
                  retry_reg <= 2'h0;
                  step_reg  <= eprom_pkg::SP_DATA;
                  state_reg <= (count_reg == 8'h01) ? eprom_pkg::ST_FIN
                                                    : eprom_pkg::ST_FETCH;
                end
              end
              default: begin
                state_reg <= eprom_pkg::ST_FIN;
              end
            endcase
          end
        end
        eprom_pkg::ST_FETCH: begin
          tmr_reg <= 16'h0000;
          if (have_reg) begin
            tx_reg    <= data_reg;
            bits_reg  <= 5'h08;
            state_reg <= eprom_pkg::ST_SLOT;
          end else if (fifo_valid) begin
            data_reg <= fifo_data;
            have_reg <= 1'b1;
          end
        end
        eprom_pkg::ST_PROG: begin
          if (tmr_reg == PROG_END) begin
            tmr_reg    <= 16'h0000;
            crc_ok_reg <= 1'b0;
            step_reg   <= eprom_pkg::SP_VER;
            tx_reg     <= 8'hFF;
            bits_reg   <= 5'h08;
            state_reg  <= eprom_pkg::ST_SLOT;
          end
        end
        eprom_pkg::ST_FIN: begin
          tmr_reg   <= 16'h0000;
          state_reg <= eprom_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= eprom_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // line only pulled low, never driven high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dq_oe   <= 1'b0;
      dq_out  <= 1'b0;
      prog_en <= 1'b0;
    end else begin
      dq_out  <= 1'b0;
      // slot starts with our falling edge
      dq_oe   <= (state_reg == eprom_pkg::ST_RST_LO) ||
                 ((state_reg == eprom_pkg::ST_SLOT) &&
                  (tmr_reg < (tx_reg[0] ? LOW1_CYC : LOW0_CYC)));
      // pulse follows the crc, or the data byte directly in speed mode
      prog_en <= (state_reg == eprom_pkg::ST_PROG) && (tmr_reg < PROG_CYC);
    end
  end

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state_reg != eprom_pkg::ST_IDLE);
      done <= (state_reg == eprom_pkg::ST_FIN);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence slot_begin;
    $rose(state_reg == eprom_pkg::ST_SLOT);
  endsequence

  sequence line_low4;
    dq_oe [*4];
  endsequence

  property slot_drives_low;
    @(posedge sys_clk) disable iff (sys_rst) slot_begin |=> line_low4;
  endproperty

  slot_falling_a : assert property (slot_drives_low)
    else $error("slot did not start with a low");

  oe_low_only_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    dq_oe |-> !dq_out) else $error("line driven high");

  prog_no_pull_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    prog_en |-> !dq_oe) else $error("pulse while pulling low");

  pulse_crc_ok_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(prog_en) && !job_reg.speed |-> $past(crc_ok_reg))
    else $error("pulse without good crc");

  start_reset_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == eprom_pkg::ST_IDLE) && start && (job.count != 8'h00)
    |=> (state_reg == eprom_pkg::ST_RST_LO) ##1 dq_oe)
    else $error("job did not begin with reset");

  done_idle_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    done |-> !dq_oe && !prog_en ##1 !done && !busy)
    else $error("done with line not idle");

  verify_inc_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == eprom_pkg::ST_NEXT) && (step_reg == eprom_pkg::SP_VER) &&
    (bits_reg == 5'h00) && !(|(rx_reg[15:8] & ~data_reg))
    |=> (addr_reg == $past(addr_reg) + 16'h0001) && (crc_reg == addr_reg))
    else $error("address or crc preload wrong");

  speed_no_crc_a : assert property (@(posedge sys_clk) disable iff (sys_rst)
    job_reg.speed |-> (step_reg != eprom_pkg::SP_CRC))
    else $error("crc read in speed mode");

endmodule : eprom_status_write_sequencer
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the EPROM write master
// Assumes: device model on the wire, shortened timing parameters
// Notes:   short slots; the master scales its sample point with them
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[FAIL] %0t %s", $time, m); \
  end \
end
module tb_top;
  // ****************
  // signals
  // ****************
  logic            sys_clk, sys_rst, start, wr_valid, wr_ready;
  logic            busy, done, dq_oe, prog_en, line;
  logic [7:0]      wr_data;
  logic [7:0]      q [16];
  logic [15:0]     a;
  eprom_pkg::job_t job;
  eprom_pkg::err_t err;
  eprom_pkg::err_t exp_q [$];
  int              failures = 0, cmp_count = 0, cyc = 0;
  integer          seed = 32'hb882_f9d6;
  // one length for both reset phases, above the model's long-low limit
  localparam logic [15:0] RST_T = 16'h00c8;

  eprom_status_write_sequencer #(
    .RST_LOW_CYC(RST_T), .RST_HIGH_CYC(RST_T), .PRES_CYC(16'h0032),
    .PROG_CYC(16'h0064), .SLOT_CYC(16'h0046), .LOW0_CYC(16'h003c)
  ) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .job(job),
    .busy(busy), .done(done), .err(err), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .dq_in(line),
    .dq_out(), .dq_oe(dq_oe), .prog_en(prog_en)
  );

  eprom_dev_model dev (
    .sys_clk(sys_clk), .dq_oe(dq_oe), .prog_en(prog_en), .line(line)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************
  // verdict, timeout, result monitor
  // ****************
  task automatic print_verdict();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cyc++;
    // whole run needs about 55k cycles
    if (cyc == 32'h0001_3880) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end

  always @(posedge sys_clk) begin
    if (done === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1, "done without job")
      if (exp_q.size() > 0) `CHK(err, exp_q.pop_front(), "job result")
    end
  end

  // ****************
  // drivers
  // ****************
  task automatic run_job(input logic sp, st, input logic [7:0] n,
                         input eprom_pkg::err_t e);
    exp_q.push_back(e);
    job   <= '{sp, st, a, n};
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    if (n != 8'h00) begin
      repeat (3) @(negedge sys_clk);
      `CHK({busy, dq_oe}, 2'b11, "reset pulse")
    end
    while (done !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask : run_job

  // fills to the brim; the 17th byte must be refused
  task automatic fill();
    for (int i = 0; i < 16; i++) begin
      wr_data  <= q[i];
      wr_valid <= 1'b1;
      @(negedge sys_clk);
      while (wr_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    wr_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wr_valid <= 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(wr_ready, 1'b0, "fifo full")
    @(posedge sys_clk);
    wr_valid <= 1'b0;
  endtask : fill

  // ****************
  // scenarios
  // ****************
  initial begin
    sys_rst  = 1'b1;
    start    = 1'b0;
    wr_valid = 1'b0;
    wr_data  = 8'h00;
    job      = '0;
    a        = 16'h0000;
    foreach (q[i]) q[i] = 8'($random(seed));
    q[15][0] = 1'b0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    run_job(1'b0, 1'b0, 8'h00, 3'b000);
    dev.mute = 1'b1;
    run_job(1'b0, 1'b1, 8'h01, 3'b100);
    dev.mute = 1'b0;
    `CHK(dev.progs, 0, "pulse without presence")
    fill();
    a = 16'($random(seed)) & 16'h00ff;
    dev.bad_crc = 1'b1;
    run_job(1'b0, 1'b0, 8'h01, 3'b000);
    `CHK(dev.progs, 1, "pulse after bad crc")
    `CHK(dev.dmem[a], q[0], "memory byte")
    `CHK(dev.adr, a + 16'h0001, "address step")
    `CHK(dev.cmd, 8'h0f, "memory command")
    a = 16'($random(seed)) & 16'h00ff;
    run_job(1'b0, 1'b1, 8'h02, 3'b000);
    `CHK({dev.smem[a], dev.smem[a + 1]}, {q[1], q[2]}, "status")
    `CHK(dev.cmd, 8'h55, "status command")
    a = 16'h0100 | (16'($random(seed)) & 16'h00ff);
    run_job(1'b1, 1'b0, 8'h0c, 3'b000);
    for (int i = 0; i < 12; i++) begin
      `CHK(dev.dmem[a + i], q[3 + i], "speed byte")
    end
    `CHK(dev.cmd, 8'hf3, "speed memory command")
    a = 16'h0100 | (16'($random(seed)) & 16'h00ff);
    dev.stuck = 8'h01;
    run_job(1'b1, 1'b1, 8'h01, 3'b001);
    `CHK(dev.progs, 19, "readback retries")
    `CHK(dev.smem[a], q[15] | 8'h01, "stuck bit")
    `CHK(dev.cmd, 8'hf5, "speed status command")
    `CHK({line, dq_oe, prog_en}, 3'b100, "idle wire")
    `CHK(exp_q.size(), 0, "missing done")
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
